// File: dv/pai_src.sv
`timescale 1ns/10ps
module pai_src
#(
  parameter int P = 8
)
(
  // clock
  input  wire logic clk_i,
  // timer state
  input  wire logic active_i,
  // prescaler tap
  output logic      pulse_o
);
  logic [7:0] cnt_reg;

  // an idle timer makes no pulses and restarts its phase
  always_ff @(posedge clk_i)
  begin
    if (!active_i || cnt_reg == 8'(P - 1))
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_reg + 8'h01;
  end

  assign pulse_o = active_i && (cnt_reg == 8'(P - 1));
endmodule : pai_src

// File: dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pin = 1'b0, act = 1'b0;
  logic              tovf = 1'b0, pulse;
  logic [3:0]        sel = 4'h0, chf = 4'h0;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wdat = 32'h0000_0000, rdat, dat_o;
  pai_pkg::pai_irq_s irq;
  int                mismatches = 0;
  int                compares = 0;

  always #4 clk_i = ~clk_i;

  pai_accum pai_accum_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .channel7_pin_i(pin), .div64_pulse_i(pulse), .timer_active_i(act),
    .channel_event_flag_i(chf), .counter_overflow_flag_i(tovf), .irq_o(irq));
  pai_src pai_src_i (.clk_i(clk_i), .active_i(act), .pulse_o(pulse));

  task test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      test_done;
    end
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  // each pulse gives one rising and one falling edge
  task pulses(input int k);
    repeat (k)
    begin
      pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      pin <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : pulses

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, pai_pkg::CTRL_OFS, 0); `CHK(rdat, 32'h0000_0000)
    wb(0, pai_pkg::COUNT_OFS, 0); `CHK(rdat, 32'h0000_0000)
    wb(0, 8'h10, 0); `CHK(rdat, 32'h0000_0000)
    $display("reset test done");
    // rising edges, timer idle, input request enabled
    wb(1, pai_pkg::CTRL_OFS, 32'h0000_000A);
    pulses(3);
    wb(0, pai_pkg::COUNT_OFS, 0); `CHK(rdat, 32'h0000_0003)
    `CHK(irq.in, 1'b1)
    wb(1, pai_pkg::FLAG_OFS, 32'h0000_0000);
    wb(0, pai_pkg::FLAG_OFS, 0); `CHK(rdat, 32'h0000_0001)
    wb(1, pai_pkg::FLAG_OFS, 32'h0000_0001);
    wb(0, pai_pkg::FLAG_OFS, 0); `CHK(rdat, 32'h0000_0000)
    `CHK(irq.in, 1'b0)
    // falling edges, request masked
    wb(1, pai_pkg::CTRL_OFS, 32'h0000_0000);
    wb(1, pai_pkg::COUNT_OFS, 32'h0000_0000);
    pulses(2);
    wb(0, pai_pkg::COUNT_OFS, 0); `CHK(rdat, 32'h0000_0002)
    `CHK(irq.in, 1'b0)
    $display("event test done");
    // wrap from all ones
    wb(1, pai_pkg::CTRL_OFS, 32'h0000_0004);
    wb(1, pai_pkg::COUNT_OFS, 32'h0000_FFFF);
    pulses(1);
    wb(0, pai_pkg::COUNT_OFS, 0); `CHK(rdat, 32'h0000_0000)
    wb(0, pai_pkg::FLAG_OFS, 0); `CHK(rdat, 32'h0000_0003)
    `CHK(irq.ovf, 1'b1)
    // fast clear on a count read
    wb(1, pai_pkg::CTRL_OFS, 32'h0000_0010);
    wb(0, pai_pkg::COUNT_OFS, 0);
    wb(0, pai_pkg::FLAG_OFS, 0); `CHK(rdat, 32'h0000_0000)
    `CHK(irq.ovf, 1'b0)
    $display("overflow test done");
    // gated on high level, three prescaler pulses, then timer idle
    wb(1, pai_pkg::CTRL_OFS, 32'h0000_0009);
    pin <= 1'b1;
    repeat (5) @(posedge clk_i);
    act <= 1'b1;
    repeat (24) @(posedge clk_i);
    act <= 1'b0;
    repeat (20) @(posedge clk_i);
    wb(0, pai_pkg::COUNT_OFS, 0); `CHK(rdat, 32'h0000_0003)
    wb(0, pai_pkg::FLAG_OFS, 0); `CHK(rdat, 32'h0000_0000)
    `CHK(irq.in, 1'b0)
    pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(0, pai_pkg::FLAG_OFS, 0); `CHK(rdat, 32'h0000_0001)
    `CHK(irq.in, 1'b1)
    // gated on low level
    wb(1, pai_pkg::CTRL_OFS, 32'h0000_0003);
    repeat (4) @(posedge clk_i);
    act <= 1'b1;
    repeat (16) @(posedge clk_i);
    act <= 1'b0;
    wb(0, pai_pkg::COUNT_OFS, 0); `CHK(rdat, 32'h0000_0005)
    wb(1, pai_pkg::FLAG_OFS, 32'h0000_0001);
    pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(0, pai_pkg::FLAG_OFS, 0); `CHK(rdat, 32'h0000_0001)
    $display("gated test done");
    // channel and timer overflow requests
    wb(1, pai_pkg::CTRL_OFS, 32'h0000_02A0);
    chf <= 4'hF;
    tovf <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(irq.chan, 4'hA)
    `CHK(irq.tov, 1'b1)
    $display("request test done");
    test_done;
  end
endmodule : tb_top

// File: rtl/pai_accum.sv
`timescale 1ns/10ps
module pai_accum
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // pin and timer links
  input  wire logic                 channel7_pin_i,
  input  wire logic                 div64_pulse_i,
  input  wire logic                 timer_active_i,
  input  wire logic [3:0]           channel_event_flag_i,
  input  wire logic                 counter_overflow_flag_i,
  // interrupt requests
  output pai_pkg::pai_irq_s         irq_o
);

  logic [pai_pkg::CTRL_W-1:0] ctrl_reg;
  pai_pkg::pai_ctrl_s         ctrl;
  logic [15:0]                pulse_count_reg;
  logic [15:0]                pulse_count_next;
  logic                       ovf_flag_reg;
  logic                       in_flag_reg;
  logic                       sync1_reg;
  logic                       sync2_reg;
  logic                       prev_reg;
  logic                       ack_reg;
  logic [31:0]                rdata_reg;
  logic                       req;
  logic                       wr;
  logic                       acc_count;
  logic                       rise;
  logic                       fall;
  logic                       sel_edge;
  logic                       gate_open;
  logic                       incr;
  logic                       wrap;
  logic                       fast_hit;
  logic                       clr_ovf;
  logic                       clr_in;

  assign ctrl = pai_pkg::pai_ctrl_s'(ctrl_reg);

  // bus decode: a request is taken once, then answered one cycle later
  assign req       = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr        = req & wb_we_i;
  assign acc_count = req & (wb_adr_i == pai_pkg::COUNT_OFS);

  // input synchroniser and edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg <= channel7_pin_i;  // RULE_20
      sync2_reg <= sync1_reg;       // RULE_20
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // the trailing edge of the active gate level equals the event edge of the same polarity
  assign sel_edge  = ctrl.pol ? rise : fall;                     // RULE_16 RULE_19 RULE_08
  assign gate_open = ctrl.pol ? ~sync2_reg : sync2_reg;          // RULE_07
  // event mode never looks at the timer; gated mode needs the prescaler tap
  assign incr      = ctrl.mode ? (div64_pulse_i & timer_active_i & gate_open)  // RULE_06 RULE_11
                               : sel_edge;                       // RULE_02 RULE_05
  assign wrap      = incr & (pulse_count_reg == pai_pkg::COUNT_MAX);

  // control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= pai_pkg::CTRL_RST;
    else if (wr && wb_adr_i == pai_pkg::CTRL_OFS)
    begin
      if (wb_sel_i[0])
        ctrl_reg[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        ctrl_reg[pai_pkg::CTRL_W-1:8] <= wb_dat_i[pai_pkg::CTRL_W-1:8];
    end
  end

  // counter: a software write wins over a count in the same cycle
  always_comb
  begin
    pulse_count_next = pulse_count_reg;
    if (incr)
      pulse_count_next = pulse_count_reg + 16'h0001;          // RULE_10
    if (wr && acc_count)
    begin
      if (wb_sel_i[0])
        pulse_count_next[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
        pulse_count_next[15:8] = wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pulse_count_reg <= pai_pkg::COUNT_RST;
    else
      pulse_count_reg <= pulse_count_next;
  end

  // flag clearing by write-one or by fast clear on counter access
  assign fast_hit = acc_count & ctrl.fast_clr;                    // RULE_18
  assign clr_ovf  = fast_hit | (wr && wb_adr_i == pai_pkg::FLAG_OFS
                                && wb_sel_i[0] && wb_dat_i[pai_pkg::OVF_FLAG_BIT]);  // RULE_17
  assign clr_in   = fast_hit | (wr && wb_adr_i == pai_pkg::FLAG_OFS
                                && wb_sel_i[0] && wb_dat_i[pai_pkg::IN_FLAG_BIT]);   // RULE_17

  // overflow flag, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovf_flag_reg <= 1'b0;
    else if (wrap)
      ovf_flag_reg <= 1'b1;                                       // RULE_03
    else if (clr_ovf)
      ovf_flag_reg <= 1'b0;
  end

  // input flag, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      in_flag_reg <= 1'b0;
    else if (sel_edge)
      in_flag_reg <= 1'b1;                                        // RULE_08
    else if (clr_in)
      in_flag_reg <= 1'b0;
  end

  // bus answer and read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      case (wb_adr_i)
        pai_pkg::CTRL_OFS:
          rdata_reg <= {22'h00_0000, ctrl_reg};
        pai_pkg::FLAG_OFS:
          rdata_reg <= {30'h0000_0000, ovf_flag_reg, in_flag_reg};
        pai_pkg::COUNT_OFS:
          rdata_reg <= {16'h0000, pulse_count_reg};
        pai_pkg::STAT_OFS:
          rdata_reg <= {27'h000_0000, timer_active_i, counter_overflow_flag_i,
                        gate_open, prev_reg, sync2_reg};
        default:
          rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // interrupt requests
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= '0;
    else
    begin
      irq_o.chan <= channel_event_flag_i & ctrl.ch_int_en;        // RULE_12
      irq_o.in   <= in_flag_reg & ctrl.in_int_en;                 // RULE_09 RULE_13
      irq_o.ovf  <= ovf_flag_reg & ctrl.ovf_int_en;               // RULE_04 RULE_14
      irq_o.tov  <= counter_overflow_flag_i & ctrl.tov_int_en;    // RULE_15
    end
  end

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_wrap;
    incr && pulse_count_reg == pai_pkg::COUNT_MAX;
  endsequence

  sequence s_pin_rise;
    !sync2_reg ##1 sync2_reg;
  endsequence

  sequence s_pin_fall;
    sync2_reg ##1 !sync2_reg;
  endsequence

  sequence s_tick;
    ctrl.mode && div64_pulse_i && timer_active_i;
  endsequence

  sequence s_count_write;
    wr && acc_count;
  endsequence

  overflow_set_a: assert property (s_wrap |=> ovf_flag_reg && pulse_count_reg == 16'h0000 // RULE_03
    || $past(wr && acc_count))
    else $error("wrap did not set overflow flag");

  event_count_a: assert property (!ctrl.mode && ctrl.pol && rise && !(wr && acc_count) // RULE_02
    |=> pulse_count_reg == $past(pulse_count_reg) + 16'h0001)
    else $error("rising edge not counted");

  event_no_timer_a: assert property (!ctrl.mode && !timer_active_i && fall && !ctrl.pol // RULE_05
    && !(wr && acc_count) |=> pulse_count_reg != $past(pulse_count_reg))
    else $error("event count blocked by timer");

  gate_stall_a: assert property (ctrl.mode && !timer_active_i && !(wr && acc_count) // RULE_11
    |=> $stable(pulse_count_reg))
    else $error("gated count moved with timer idle");

  gate_level_a: assert property (ctrl.mode && div64_pulse_i && timer_active_i // RULE_07
    && (sync2_reg == ctrl.pol) && !(wr && acc_count) |=> $stable(pulse_count_reg))
    else $error("counted at inactive gate level");

  trailing_flag_a: assert property (s_pin_rise ##1 (ctrl.mode && !ctrl.pol && !sync2_reg) // RULE_08
    |=> in_flag_reg)
    else $error("trailing edge did not set flag");

  sync_delay_a: assert property ($rose(channel7_pin_i) ##1 channel7_pin_i // RULE_20
    ##1 channel7_pin_i |=> sync2_reg)
    else $error("synchroniser delay wrong");

  fast_clear_a: assert property (fast_hit && !wrap && !sel_edge // RULE_18
    |=> !ovf_flag_reg && !in_flag_reg)
    else $error("fast clear missed");

  ovf_irq_a: assert property (ovf_flag_reg && ctrl.ovf_int_en // RULE_04
    ##1 $stable(ctrl_reg) |-> irq_o.ovf)
    else $error("overflow request missing");

  in_irq_a: assert property (!ctrl.in_int_en ##1 $stable(ctrl_reg) |-> !irq_o.in) // RULE_09
    else $error("input request while disabled");

  chan_irq_a: assert property (1'b1 |=> irq_o.chan == // RULE_12
    ($past(channel_event_flag_i) & $past(ctrl.ch_int_en)))
    else $error("channel request mismatch");

  tov_irq_a: assert property (counter_overflow_flag_i && ctrl.tov_int_en // RULE_15
    |=> irq_o.tov)
    else $error("timer overflow request missing");

  bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not single cycle");

  rise_ignored_a: assert property (!ctrl.mode && !ctrl.pol && rise // RULE_19
    && !(wr && acc_count) |=> $stable(pulse_count_reg))
    else $error("rising edge counted in falling mode");

  fall_ignored_a: assert property (!ctrl.mode && ctrl.pol && fall // RULE_19
    && !(wr && acc_count) |=> $stable(pulse_count_reg))
    else $error("falling edge counted in rising mode");

  gate_count_a: assert property (s_tick ##0 (sync2_reg != ctrl.pol) // RULE_06 RULE_10
    ##0 !(wr && acc_count) |=> pulse_count_reg == $past(pulse_count_reg) + 16'h0001)
    else $error("open gate tick not counted");

  gate_no_tick_a: assert property (ctrl.mode && !div64_pulse_i && !(wr && acc_count) // RULE_06
    |=> $stable(pulse_count_reg))
    else $error("gated count moved without tick");

  event_idle_a: assert property (!ctrl.mode && !rise && !fall && !(wr && acc_count) // RULE_02
    |=> $stable(pulse_count_reg))
    else $error("event count moved without edge");

  gate_low_flag_a: assert property (s_pin_rise ##0 (ctrl.mode && ctrl.pol) // RULE_08
    |=> in_flag_reg)
    else $error("low gate trailing edge missed");

  event_flag_a: assert property (s_pin_fall ##0 (!ctrl.mode && !ctrl.pol) // RULE_13
    |=> in_flag_reg)
    else $error("event edge did not set flag");

  ovf_irq_after_a: assert property (s_wrap ##1 ctrl.ovf_int_en |=> irq_o.ovf) // RULE_14
    else $error("overflow request late");

  ovf_irq_off_a: assert property (!ctrl.ovf_int_en |=> !irq_o.ovf) // RULE_04
    else $error("overflow request while disabled");

  in_irq_on_a: assert property (in_flag_reg && ctrl.in_int_en |=> irq_o.in) // RULE_13
    else $error("input request missing");

  tov_irq_off_a: assert property (!ctrl.tov_int_en |=> !irq_o.tov) // RULE_15
    else $error("timer request while disabled");

  ovf_hold_a: assert property (ovf_flag_reg && !acc_count // RULE_17
    && !(wr && wb_adr_i == pai_pkg::FLAG_OFS) |=> ovf_flag_reg)
    else $error("overflow flag lost");

  in_clear_a: assert property (wr && wb_adr_i == pai_pkg::FLAG_OFS && wb_sel_i[0] // RULE_17
    && wb_dat_i[pai_pkg::IN_FLAG_BIT] && !rise && !fall |=> !in_flag_reg)
    else $error("write one did not clear input flag");

  no_fast_a: assert property (!ctrl.fast_clr && in_flag_reg // RULE_18
    && !(wr && wb_adr_i == pai_pkg::FLAG_OFS) |=> in_flag_reg)
    else $error("input flag cleared without fast clear");

  wrap_only_a: assert property (!ovf_flag_reg && !incr // RULE_03
    |=> !ovf_flag_reg)
    else $error("overflow flag set without wrap");

  sync_first_a: assert property (1'b1 |=> sync1_reg == $past(channel7_pin_i)) // RULE_20
    else $error("first synchroniser stage wrong");

  count_write_a: assert property (s_count_write ##0 (wb_sel_i[1:0] == 2'b11)
    |=> pulse_count_reg == $past(wb_dat_i[15:0]))
    else $error("count write lost");

  rdata_hold_a: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without read");

  ack_idle_a: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");

endmodule : pai_accum

// File: rtl/pai_pkg.sv
// Contract
// [RULE_01] Software detaches channel-7 compare output before using the pin as accumulator input.
// [RULE_02] Event mode: pulse_count counts active input edges since reset.
// [RULE_03] accum_overflow_flag sets when pulse_count wraps from all ones to zero.
// [RULE_04] Overflow interrupt request only while accum_overflow_int_enable is set.
// [RULE_05] Event counting ignores the timer enable.
// [RULE_06] Gated mode counts divide-by-64 pulses only while input is active.
// [RULE_07] Gated mode: polarity select picks high or low active level.
// [RULE_08] Gated mode: trailing edge of active level sets accum_input_flag.
// [RULE_09] Input interrupt request only while accum_input_int_enable is set.
// [RULE_10] Gated mode: pulse_count counts gated divide-by-64 pulses since reset.
// [RULE_11] Divide-by-64 pulses absent while timer inactive; gated counting stalls.
// [RULE_12] Channel 7-4 requests assert on event flag with channel enable set.
// [RULE_13] Accumulator input request asserts in both modes when enabled.
// [RULE_14] Accumulator overflow request asserts after overflow while enabled.
// [RULE_15] Timer overflow request asserts after counter overflow while enabled.
// [RULE_16] Mode/polarity: 00 fall, 01 rise, 10 gate high, 11 gate low.
// [RULE_17] Writing one clears a flag; writing zero leaves it.
// [RULE_18] With fast clear set, any pulse_count access clears both flags.
// [RULE_19] Event mode: polarity select picks falling or rising edges.
// [RULE_20] Input passes two-stage synchroniser; pulses of two clocks may be missed.
package pai_pkg;

  // register byte offsets
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  FLAG_OFS   = 8'h04;
  localparam logic [7:0]  COUNT_OFS  = 8'h08;
  localparam logic [7:0]  STAT_OFS   = 8'h0C;

  // control field positions
  localparam int          MODE_BIT   = 0;
  localparam int          POL_BIT    = 1;
  localparam int          OVF_IE_BIT = 2;
  localparam int          IN_IE_BIT  = 3;
  localparam int          FAST_BIT   = 4;
  localparam int          TOV_IE_BIT = 5;
  localparam int          CH_IE_LSB  = 6;
  localparam int          CTRL_W     = 10;

  // flag field positions
  localparam int          IN_FLAG_BIT  = 0;
  localparam int          OVF_FLAG_BIT = 1;

  // reset values and counter maximum
  localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h000;
  localparam logic [15:0]       COUNT_RST = 16'h0000;
  localparam logic [15:0]       COUNT_MAX = 16'hFFFF;

  typedef struct packed {
    logic [3:0] ch_int_en;
    logic       tov_int_en;
    logic       fast_clr;
    logic       in_int_en;
    logic       ovf_int_en;
    logic       pol;
    logic       mode;
  } pai_ctrl_s;

  typedef struct packed {
    logic [3:0] chan;
    logic       in;
    logic       ovf;
    logic       tov;
  } pai_irq_s;

endpackage : pai_pkg
